// file: display_host_port.v
// host controller driving a display module's interface pins
// assumes user handshake on clock; device pins asynchronous
//
// Contract
// - parallel byte is data when dc high, command when dc low.
// - serial bits are data when dc high, command when dc low.
// - in i2c mode dc level becomes target address bit zero.
// - enable mode: direction high reads, low writes, set before enable.
// - enable mode: transfer only while enable high and chip select low.
// - strobe mode: write starts with write strobe low and chip select low.
// - strobe mode: read starts with read strobe low and chip select low.
// - eight-bit data bus driven by host only on writes.
// - serial mode: data on pin one, clock on pin zero.
// - i2c mode: pins two and one joined as sda, scl on zero.
`timescale 1ns/100ps
`include "disp_host_regs.vh"
module display_host_port #(
    parameter RESET_COUNT = `RESET_CYCLES
) (
    input wire clock,
    input wire reset_n,
    input wire [1:0] mode,
    input wire req_valid,
    input wire req_read,
    input wire req_dc,
    input wire [7:0] req_data,
    output reg req_ready,
    output reg [7:0] rsp_data,
    output reg rsp_valid,
    output reg iface_select_a,
    output reg iface_select_b,
    output reg reset_n_input,
    output reg cs_n,
    output reg dc,
    output reg rw_wr,
    output reg e_rd,
    output reg [7:0] host_data_out,
    output reg [7:0] host_data_oe,
    input wire [7:0] host_data_in
);
// ----------------------------------------
// states
// ----------------------------------------
localparam S_RESET = 6'h01;
localparam S_IDLE = 6'h02;
localparam S_SETUP = 6'h04;
localparam S_STROBE = 6'h08;
localparam S_HOLD = 6'h10;
localparam S_SHIFT = 6'h20;
localparam [6:0] I2C_ADDR = `I2C_BASE_ADDR;
reg [5:0] state;
reg [15:0] rst_count;
reg [3:0] bitn;
reg [8:0] shreg;
reg [1:0] mode_q;
reg rd_op;
reg [2:0] i2c_byte;
reg [7:0] sync1, sync2;
wire tick;
wire sda_in = sync2[1];
phase_divider #(.COUNT(`PHASE_CYCLES)) div (
    .clock(clock),
    .reset_n(reset_n),
    .run(state != S_IDLE && state != S_RESET),
    .tick(tick)
);
// ----------------------------------------
// pin synchroniser
// ----------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        sync1 <= 8'h00;
        sync2 <= 8'h00;
    end else begin
        sync1 <= host_data_in;
        sync2 <= sync1;
    end
end
function [1:0] select_code;
    input [1:0] m;
    begin
        case (m)
            `MODE_ESTROBE: select_code = 2'h3;
            `MODE_RWSTROBE: select_code = 2'h1;
            `MODE_SERIAL: select_code = 2'h0;
            default: select_code = 2'h2;
        endcase
    end
endfunction
// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        state <= S_RESET;
        rst_count <= 16'h0000;
        mode_q <= `MODE_ESTROBE;
        req_ready <= 1'b0;
        rsp_data <= 8'h00;
        rsp_valid <= 1'b0;
        iface_select_a <= 1'b1;
        iface_select_b <= 1'b1;
        reset_n_input <= 1'b0;
        cs_n <= 1'b1;
        dc <= 1'b0;
        rw_wr <= 1'b1;
        e_rd <= 1'b0;
        host_data_out <= 8'h00;
        host_data_oe <= 8'h00;
        bitn <= 4'h0;
        shreg <= 9'h000;
        rd_op <= 1'b0;
        i2c_byte <= 3'h0;
    end else begin
        rsp_valid <= 1'b0;
        case (state)
            S_RESET: begin
                // mode sampled only here; select pins then stay fixed
                mode_q <= mode;
                {iface_select_b, iface_select_a} <= select_code(mode);
                e_rd <= (mode == `MODE_RWSTROBE);
                rw_wr <= (mode != `MODE_ESTROBE);
                host_data_out <= (mode[1]) ? 8'h07 : 8'h00;
                host_data_oe <= (mode[1]) ? 8'h07 : 8'h00;
                rst_count <= rst_count + 16'h0001;
                if (rst_count == RESET_COUNT[15:0]) begin
                    reset_n_input <= 1'b1;
                    state <= S_IDLE;
                    req_ready <= 1'b1;
                end
            end
            S_IDLE: begin
                if (req_valid) begin
                    req_ready <= 1'b0;
                    rd_op <= req_read & ~mode_q[1];
                    dc <= req_dc;
                    bitn <= 4'h0;
                    i2c_byte <= 3'h0;
                    case (mode_q)
                        `MODE_ESTROBE: begin
                            cs_n <= 1'b0;
                            rw_wr <= req_read;
                            host_data_out <= req_data;
                            host_data_oe <= req_read ? 8'h00 : 8'hff;
                            state <= S_SETUP;
                        end
                        `MODE_RWSTROBE: begin
                            cs_n <= 1'b0;
                            host_data_out <= req_data;
                            host_data_oe <= req_read ? 8'h00 : 8'hff;
                            state <= S_SETUP;
                        end
                        `MODE_SERIAL: begin
                            cs_n <= 1'b0;
                            shreg <= {req_data, 1'b0};
                            state <= S_SHIFT;
                        end
                        default: begin
                            // start condition: sda falls while scl high on the first transfer only; later transfers find the pins released here
                            host_data_out <= 8'h01;
                            // dc replaces the address low bit; write direction bit follows
                            shreg <= {I2C_ADDR[6:1], req_dc, 1'b0, 1'b1};
                            state <= S_SHIFT;
                        end
                    endcase
                end
            end
            S_SETUP: if (tick) begin
                if (mode_q == `MODE_ESTROBE)
                    e_rd <= 1'b1;
                else if (rd_op)
                    e_rd <= 1'b0;
                else
                    rw_wr <= 1'b0;
                state <= S_STROBE;
            end
            S_STROBE: if (tick) begin
                e_rd <= (mode_q == `MODE_RWSTROBE);
                rw_wr <= (mode_q == `MODE_ESTROBE) ? rd_op : 1'b1;
                state <= S_HOLD;
            end
            S_HOLD: begin
                // two sync stages: the byte seen under the strobe lands two cycles late
                if (rd_op) begin
                    rsp_data <= sync2;
                    rsp_valid <= 1'b1;
                    rd_op <= 1'b0;
                end
                if (tick) begin
                    cs_n <= 1'b1;
                    host_data_oe <= 8'h00;
                    state <= S_IDLE;
                    req_ready <= 1'b1;
                end
            end
            S_SHIFT: if (tick) begin
                if (mode_q == `MODE_SERIAL) begin
                    // clock on pin zero, data on pin one, msb first
                    host_data_oe <= 8'h03;
                    if (!host_data_out[0] && bitn != 4'h0) begin
                        host_data_out[0] <= 1'b1;
                    end else if (bitn == 4'h8) begin
                        // keep clock driven low: a floating clock gives false edges
                        cs_n <= 1'b1;
                        host_data_out <= 8'h00;
                        host_data_oe <= 8'h03;
                        state <= S_IDLE;
                        req_ready <= 1'b1;
                    end else begin
                        host_data_out <= {6'h00, shreg[8], 1'b0};
                        shreg <= {shreg[7:0], 1'b0};
                        bitn <= bitn + 4'h1;
                    end
                end else begin
                    // sda out on pin two, sense on pin one, scl on zero
                    host_data_oe <= 8'h05;
                    if (host_data_out[0]) begin
                        host_data_out[0] <= 1'b0;
                        if (bitn == 4'h9) begin
                            bitn <= 4'h0;
                            i2c_byte <= i2c_byte + 3'h1;
                            if (i2c_byte == 3'h2) begin
                                host_data_out <= 8'h00;
                            end else if (i2c_byte == 3'h0) begin
                                shreg <= {1'b0, req_dc, 6'h00, 1'b1};
                            end else begin
                                shreg <= {req_data, 1'b1};
                            end
                        end
                    end else if (i2c_byte == 3'h3) begin
                        // stop: scl and sda driven high together, scl pulled low again for one tick, then both driven high and released
                        host_data_out <= 8'h05;
                        i2c_byte <= 3'h4;
                    end else if (i2c_byte == 3'h4) begin
                        host_data_out <= 8'h05;
                        host_data_oe <= 8'h00;
                        state <= S_IDLE;
                        req_ready <= 1'b1;
                    end else begin
                        // drive sda high, not released, for acknowledge on the ninth bit
                        host_data_out <= {5'h00, shreg[8], 1'b0, 1'b1};
                        shreg <= {shreg[7:0], 1'b1};
                        bitn <= bitn + 4'h1;
                        rsp_data[0] <= sda_in;
                    end
                end
            end
            default: state <= S_RESET;
        endcase
    end
end
endmodule

// file: disp_host_regs.vh
// constants for the display host port controller
// assumes inclusion by the host port design file only
`ifndef DISP_HOST_REGS_VH
`define DISP_HOST_REGS_VH
// ----------------------------------------
// interface modes
// ----------------------------------------
`define MODE_ESTROBE 2'h0
`define MODE_RWSTROBE 2'h1
`define MODE_SERIAL 2'h2
`define MODE_I2C 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_MHZ 20
`define PHASE_NS 100
`define PHASE_CYCLES ((`PHASE_NS * `CLOCK_MHZ + 999) / 1000)
`define RESET_NS 3000
`define RESET_CYCLES ((`RESET_NS * `CLOCK_MHZ + 999) / 1000)
`define I2C_BASE_ADDR 7'h3c
`endif

// file: phase_divider.v
// enable pulse divider for the host port phases
// assumes one clock domain; period set by parameter
`timescale 1ns/100ps
module phase_divider #(
    parameter COUNT = 2
) (
    input wire clock,
    input wire reset_n,
    input wire run,
    output reg tick
);
reg [7:0] count;
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        count <= 8'h00;
        tick <= 1'b0;
    end else if (!run) begin
        count <= 8'h00;
        tick <= 1'b0;
    end else if (count == COUNT[7:0] - 8'h01) begin
        count <= 8'h00;
        tick <= 1'b1;
    end else begin
        count <= count + 8'h01;
        tick <= 1'b0;
    end
end
endmodule

// file: display_host_port_chk.sv
// pin checker for the display host port
// assumes bind onto display_host_port, one clock domain
`timescale 1ns/100ps
module display_host_port_chk #(
    parameter RESET_COUNT = 4
) (
    input wire clock,
    input wire reset_n,
    input wire req_ready,
    input wire rsp_valid,
    input wire iface_select_a,
    input wire iface_select_b,
    input wire reset_n_input,
    input wire cs_n,
    input wire dc,
    input wire rw_wr,
    input wire e_rd,
    input wire [7:0] host_data_out,
    input wire [7:0] host_data_oe
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    reg [7:0] cnt;
    wire [1:0] sel = {iface_select_b, iface_select_a};
    // mode checks wait for the device reset: selects hold their reset value 11 until the first S_RESET clock
    wire e_md = reset_n_input && sel == 2'h3;
    wire s_md = reset_n_input && sel == 2'h1;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) cnt <= 8'h00;
        else if (!reset_n_input && cnt != 8'hff) cnt <= cnt + 8'h1;
    end
    property p_len; $rose(reset_n_input) |-> cnt >= RESET_COUNT && req_ready; endproperty
    a_len: assert property (p_len) else $error("device reset too short");
    property p_sel; reset_n_input && $past(reset_n_input) |-> $stable(sel); endproperty
    a_sel: assert property (p_sel) else $error("interface select moved");
    property p_ecs; e_md && e_rd |-> !cs_n; endproperty
    a_ecs: assert property (p_ecs) else $error("enable without select");
    property p_erw; e_md && $rose(e_rd) |-> $stable(rw_wr); endproperty
    a_erw: assert property (p_erw) else $error("direction moved at enable");
    property p_eoe; e_md && (cs_n || rw_wr) |-> host_data_oe == 8'h00; endproperty
    a_eoe: assert property (p_eoe) else $error("bus driven outside write");
    property p_scs; s_md && !(rw_wr && e_rd) |-> !cs_n && (rw_wr || e_rd); endproperty
    a_scs: assert property (p_scs) else $error("strobe without select");
    property p_soe; s_md && !e_rd |-> host_data_oe == 8'h00; endproperty
    a_soe: assert property (p_soe) else $error("bus driven during read");
    property p_dc; reset_n_input && sel != 2'h2 && !cs_n && !$past(cs_n) |-> $stable(dc); endproperty
    a_dc: assert property (p_dc) else $error("data command moved");
    cover property (rsp_valid);
    cover property ($rose(reset_n_input));
    cover property (e_md && e_rd);
endmodule
bind display_host_port display_host_port_chk #(.RESET_COUNT(RESET_COUNT)) u_chk (
    .clock(clock), .reset_n(reset_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .iface_select_a(iface_select_a), .iface_select_b(iface_select_b),
    .reset_n_input(reset_n_input), .cs_n(cs_n), .dc(dc), .rw_wr(rw_wr), .e_rd(e_rd),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));

// file: display_dev_model.sv
// device side pin model of the display module
// assumes the bench clock samples the pins
`timescale 1ns/100ps
module display_dev_model (
    input wire clock,
    input wire rst_n,
    input wire [1:0] sel,
    input wire cs_n,
    input wire dc,
    input wire rw_wr,
    input wire e_rd,
    input wire [7:0] hout,
    input wire [7:0] hoe,
    input wire [7:0] rd_val,
    output wire [7:0] din,
    output reg got,
    output reg [8:0] word
);
    // ----------------------------------------
    // pins
    // ----------------------------------------
    reg [7:0] last;
    reg [2:0] prv;
    reg [2:0] bitc;
    reg [6:0] sh;
    wire e_md = sel == 2'h3;
    wire dev_oe = !cs_n && (e_md ? rw_wr && e_rd : sel == 2'h1 && !e_rd);
    // no keeper: a released bit shows the inverse of its last level
    wire [7:0] hd = (hoe & hout) | (~hoe & (dev_oe ? rd_val : ~last));
    assign din = hd;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            got <= 1'b0;
            bitc <= 3'h0;
            last <= 8'h00;
            prv <= 3'h0;
        end else begin
            got <= 1'b0;
            last <= hd;
            prv <= {hd[0], rw_wr, e_rd};
            if (!cs_n && (e_md ? prv[0] && !e_rd && !rw_wr
                : sel == 2'h1 && !prv[1] && rw_wr)) begin
                got <= 1'b1;
                word <= {dc, hd};
            end
            if (sel == 2'h0 && !cs_n && hd[0] && !prv[2]) begin
                sh <= {sh[5:0], hd[1]};
                bitc <= bitc + 3'h1;
                got <= bitc == 3'h7;
                word <= {dc, sh, hd[1]};
            end
        end
    end
endmodule

// file: test_display_host_port.sv
// self-checking bench for the display host port
// assumes the pin model answers as the display device
`timescale 1ns/100ps
module test_display_host_port;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg [1:0] mode = 2'h0;
    reg req_valid = 1'b0;
    reg req_read = 1'b0;
    reg req_dc = 1'b0;
    reg [7:0] req_data = 8'h00;
    reg [7:0] rd_val = 8'h00;
    reg [31:0] seed = 32'ha8a24c2b;
    reg [9:0] e;
    reg [9:0] q [$];
    integer bad_count = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer m;
    integer k;
    integer n;
    wire req_ready, rsp_valid, iface_select_a, iface_select_b, reset_n_input;
    wire cs_n, dc, rw_wr, e_rd, got;
    wire [7:0] rsp_data, host_data_out, host_data_oe, host_data_in;
    wire [8:0] word;
    always #25 clock = ~clock;
    display_host_port #(.RESET_COUNT(4)) u_display_host_port (.clock(clock),
        .reset_n(reset_n), .mode(mode), .req_valid(req_valid), .req_read(req_read),
        .req_dc(req_dc), .req_data(req_data), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .iface_select_a(iface_select_a),
        .iface_select_b(iface_select_b), .reset_n_input(reset_n_input), .cs_n(cs_n),
        .dc(dc), .rw_wr(rw_wr), .e_rd(e_rd), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .host_data_in(host_data_in));
    display_dev_model u_display_dev_model (.clock(clock), .rst_n(reset_n_input),
        .sel({iface_select_b, iface_select_a}), .cs_n(cs_n), .dc(dc), .rw_wr(rw_wr),
        .e_rd(e_rd), .hout(host_data_out), .hoe(host_data_oe), .rd_val(rd_val),
        .din(host_data_in), .got(got), .word(word));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task check(input [63:0] what, input [9:0] seen, input [9:0] want);
        begin
            tests_run = tests_run + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("wrong value %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task give_verdict;
        begin
            if (bad_count == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // acks are ignored by the design, so i2c traffic only has to complete
    task send(input r, input c, input [7:0] d);
        begin
            n = 0;
            @(posedge clock);
            while (req_ready !== 1'b1 && n < 500) begin
                @(posedge clock);
                n = n + 1;
            end
            if (r) rd_val <= d;
            if (m != 3) q.push_back({r, c, d});
            req_valid <= 1'b1;
            req_read <= r;
            req_dc <= c;
            req_data <= d;
            @(posedge clock);
            req_valid <= 1'b0;
        end
    endtask
    always @(posedge clock) begin
        if (got === 1'b1 || rsp_valid === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : 10'h3ff;
            if (rsp_valid === 1'b1)
                check("read", {1'b1, e[8], rsp_data}, e);
            else
                check("write", {1'b0, word}, e);
        end
    end
    // mode is taken only in reset, so every mode gets its own reset
    initial begin
        for (m = 0; m < 4; m = m + 1) begin
            @(posedge clock);
            reset_n <= 1'b0;
            mode <= m[1:0];
            repeat (5) @(posedge clock);
            reset_n <= 1'b1;
            for (k = 0; k < 6; k = k + 1) begin
                seed = xs(seed);
                send(k[0] && m < 2, seed[8], seed[7:0]);
            end
            n = 0;
            while ((q.size() > 0 || req_ready !== 1'b1) && n < 3000) begin
                @(posedge clock);
                n = n + 1;
            end
            check("drain", {q.size() != 0, req_ready}, 10'h1);
        end
        give_verdict;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    end
endmodule
